// file: logic/lts_pkg.sv
package lts_pkg;
	localparam int LTS_DW = 16;
	localparam int LTS_NW = 7;
	localparam int LTS_CW = 16;
	localparam int LTS_AW = 8;
	// Register byte addresses
	localparam logic [7:0] LTS_A_CTRL = 8'h00;
	localparam logic [7:0] LTS_A_STAT = 8'h04;
	localparam logic [7:0] LTS_A_TCNT = 8'h08;
	localparam logic [7:0] LTS_A_TDLY = 8'h0C;
	localparam logic [7:0] LTS_A_WBASE = 8'h10;
	localparam logic [7:0] LTS_A_WEND = 8'h80;
	localparam logic [3:0] LTS_S_WVAL = 4'h0;
	localparam logic [3:0] LTS_S_WCARE = 4'h4;
	localparam logic [3:0] LTS_S_WCFG = 4'h8;
	localparam int LTS_WSHIFT = 4;
	// CTRL fields, plus TDLY unit and word invert bits
	localparam int LTS_C_MODE = 0;
	localparam int LTS_C_FALL = 2;
	localparam int LTS_C_GEDGE = 3;
	localparam int LTS_C_GEN = 4;
	localparam int LTS_C_MEN = 5;
	localparam int LTS_C_START = 6;
	localparam int LTS_C_STOP = 7;
	localparam int LTS_C_LAST = 8;
	localparam int LTS_D_UNIT = 16;
	localparam int LTS_W_INV = 16;
	localparam logic [2:0] LTS_LAST_MAX = 3'h6;
	// STATUS fields
	localparam int LTS_ST_ACT = 0;
	localparam int LTS_ST_ACQ = 1;
	localparam int LTS_ST_DONE = 3;
	localparam int LTS_ST_MOUT = 4;
	localparam int LTS_ST_STEP = 5;
	localparam int LTS_ST_TCNT = 16;
	// Timing
	localparam int LTS_CLK_NS = 10;
	localparam int LTS_MPULSE_NS = 60;
	localparam logic [3:0] LTS_MPULSE_CYC = 4'(LTS_MPULSE_NS / LTS_CLK_NS + 1);
	localparam int LTS_MATCH_LAT = 3;

	typedef enum logic [1:0] {
		LTS_PAR = 2'b00,
		LTS_QPAR = 2'b01,
		LTS_SEQ = 2'b10,
		LTS_IMM = 2'b11
	} lts_mode_e;
	typedef enum logic [1:0] {
		LTS_DU_STATE = 2'b00,
		LTS_DU_WORD = 2'b01,
		LTS_DU_TIME = 2'b10,
		LTS_DU_RSVD = 2'b11
	} lts_dunit_e;
	typedef enum logic [1:0] {
		LTS_IDLE = 2'b00,
		LTS_ARM = 2'b01,
		LTS_DELAY = 2'b10,
		LTS_SPARE = 2'b11
	} lts_acq_e;

	typedef struct packed {
		logic [LTS_AW-1:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} lts_apb_req_s;
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} lts_apb_rsp_s;
	typedef struct packed {
		logic [LTS_DW-1:0] value;
		logic [LTS_DW-1:0] care;
		logic [LTS_CW-1:0] dcnt;
		logic inv;
	} lts_word_s;
	typedef struct packed {
		logic [LTS_DW-1:0] probe_s1;
		logic [LTS_DW-1:0] probe_s2;
		logic tclk_s1;
		logic tclk_s2;
		logic tclk_s3;
		logic gate_s1;
		logic gate_s2;
		logic gate_s3;
		lts_mode_e mode;
		logic fall;
		logic gedge;
		logic gen;
		logic men;
		logic [2:0] last;
		lts_word_s [LTS_NW-1:0] word;
		logic [LTS_CW-1:0] tpreset;
		logic [LTS_CW-1:0] tdly;
		lts_dunit_e dunit;
		lts_acq_e acq;
		logic [2:0] step;
		logic [LTS_NW-1:0][LTS_CW-1:0] wcnt;
		logic [LTS_CW-1:0] tcnt;
		logic [LTS_CW-1:0] dcnt;
		logic gate_seen;
		logic [LTS_MATCH_LAT-1:0] mpipe;
		logic mout;
		logic [3:0] mstr;
		logic done;
		logic rdy;
		logic [31:0] prdata;
		logic pslverr;
	} lts_state_s;
endpackage

// file: logic/lts_trigger_seq.sv
// What this block does
// - Seven trigger words, each with delay count.
// - Parallel modes: any configured word triggers.
// - Sequential: arming words before firing word.
// - Immediate: next word on next sample.
// - Any word, clock, delay combination allowed.
// - Per-word match or mismatch triggering.
// - Preset trigger count, counted against preset.
// - Gate input enables internal matching.
// - Gate edge or level sensitive.
// - All don't-care word: gate triggers.
// - Defined word: gate only qualifies.
// - Trigger delay 0..64k states, words, time.
// - Match output high on trigger word.
// - Match output holds until next sample.
// - Match output two sample clocks late.
// - Match pulses stretched beyond 60 ns.
// - Active output high during acquisition.
// - Sample on selected target clock edge.
// - Each bit high, low or don't-care.
`timescale 1ns/10ps
`default_nettype none
module lts_trigger_seq (
	input wire logic clk_sys, // System clock, 100 MHz
	input wire logic resetn, // Async reset, active low
	input wire logic ce, // Clock enable, freezes all state
	input wire lts_pkg::lts_apb_req_s apb_req, // APB request
	output var lts_pkg::lts_apb_rsp_s apb_rsp, // APB response
	input wire logic tgt_clk, // Target sampling clock
	input wire logic [lts_pkg::LTS_DW-1:0] probe_word, // Probe inputs
	input wire logic gate_in, // External gate input
	output var logic match_out, // Match output
	output var logic acq_active // Acquisition running
);
	import lts_pkg::*;

	lts_state_s q;
	lts_state_s n;
	logic tick;
	logic gate_rise;
	logic gate_ok;
	logic [LTS_NW-1:0] raw;
	logic [LTS_NW-1:0] used;
	logic [LTS_NW-1:0] hit;
	logic occ;
	logic evt;
	logic dstep;
	logic setup;
	logic wr;
	logic [LTS_AW-1:0] wofs;
	logic [2:0] widx;
	logic in_words;
	logic [31:0] rdata;
	logic rerr;

	// Address decode shared by read and write
	always_comb begin
		wofs = apb_req.paddr - LTS_A_WBASE;
		widx = wofs[LTS_WSHIFT+2:LTS_WSHIFT];
		in_words = (apb_req.paddr >= LTS_A_WBASE) && (apb_req.paddr < LTS_A_WEND);
		rdata = '0;
		rerr = 1'b0;
		if (apb_req.paddr[1:0] != 2'h0) begin
			rerr = 1'b1;
		end else if (in_words) begin
			case (wofs[LTS_WSHIFT-1:0])
				LTS_S_WVAL: rdata[LTS_DW-1:0] = q.word[widx].value;
				LTS_S_WCARE: rdata[LTS_DW-1:0] = q.word[widx].care;
				LTS_S_WCFG: rdata[LTS_W_INV:0] = {q.word[widx].inv, q.word[widx].dcnt};
				default: rerr = 1'b1;
			endcase
		end else begin
			case (apb_req.paddr)
				LTS_A_CTRL: begin
					rdata[LTS_C_MODE+:2] = q.mode;
					rdata[LTS_C_FALL] = q.fall;
					rdata[LTS_C_GEDGE] = q.gedge;
					rdata[LTS_C_GEN] = q.gen;
					rdata[LTS_C_MEN] = q.men;
					rdata[LTS_C_LAST+:3] = q.last;
				end
				LTS_A_STAT: begin
					rdata[LTS_ST_ACT] = (q.acq != LTS_IDLE);
					rdata[LTS_ST_ACQ+:2] = q.acq;
					rdata[LTS_ST_DONE] = q.done;
					rdata[LTS_ST_MOUT] = q.mout;
					rdata[LTS_ST_STEP+:3] = q.step;
					rdata[LTS_ST_TCNT+:LTS_CW] = q.tcnt;
				end
				LTS_A_TCNT: rdata[LTS_CW-1:0] = q.tpreset;
				LTS_A_TDLY: rdata[LTS_D_UNIT+1:0] = {q.dunit, q.tdly};
				default: rerr = 1'b1;
			endcase
		end
	end

	// Word compare against the synchronised probe word
	always_comb begin
		for (int i = 0; i < LTS_NW; i++) begin
			used[i] = (3'(i) <= q.last);
			raw[i] = ((((q.probe_s2 ^ q.word[i].value) & q.word[i].care) == '0)
				^ q.word[i].inv) && gate_ok;
			if (q.gen && (q.word[i].care == '0)) begin
				raw[i] = gate_ok;
			end
			hit[i] = raw[i] && (q.wcnt[i] == q.word[i].dcnt);
		end
	end

	always_comb begin
		n = q;
		// Two-flop synchronisers; clock and gate add a third stage that only feeds edge detection
		n.probe_s1 = probe_word;
		n.probe_s2 = q.probe_s1;
		n.tclk_s1 = tgt_clk;
		n.tclk_s2 = q.tclk_s1;
		n.tclk_s3 = q.tclk_s2;
		n.gate_s1 = gate_in;
		n.gate_s2 = q.gate_s1;
		n.gate_s3 = q.gate_s2;
		tick = q.fall ? (q.tclk_s3 & ~q.tclk_s2) : (~q.tclk_s3 & q.tclk_s2);
		gate_rise = q.gate_s2 & ~q.gate_s3;
		// Edge mode remembers an edge until the next sample consumes it
		gate_ok = !q.gen || (q.gedge ? (q.gate_seen | gate_rise) : q.gate_s2);
		if (tick) begin
			n.gate_seen = 1'b0;
		end
		if (gate_rise) begin
			n.gate_seen = 1'b1;
		end
		occ = tick && (q.acq != LTS_IDLE) && ((raw & used) != '0);
		evt = 1'b0;
		dstep = 1'b0;

		case (q.acq)
			LTS_ARM: begin
				if (tick) begin
					case (q.mode)
						LTS_PAR, LTS_QPAR: begin
							for (int i = 0; i < LTS_NW; i++) begin
								if (used[i] && raw[i]) begin
									n.wcnt[i] = hit[i] ? '0 : q.wcnt[i] + 16'h0001;
								end
							end
							evt = ((hit & used) != '0);
						end
						LTS_SEQ, LTS_IMM: begin
							if (hit[q.step]) begin
								n.wcnt[q.step] = '0;
								if (q.step == q.last) begin
									evt = 1'b1;
									n.step = '0;
								end else begin
									n.step = q.step + 3'h1;
								end
							end else if (raw[q.step]) begin
								n.wcnt[q.step] = q.wcnt[q.step] + 16'h0001;
							end else if (q.mode == LTS_IMM && q.step != '0) begin
								n.step = '0;
								n.wcnt = '0;
							end
						end
						default: n.step = '0;
					endcase
				end
				if (evt) begin
					if (q.tcnt == q.tpreset) begin
						n.acq = LTS_DELAY;
						n.dcnt = '0;
					end else begin
						n.tcnt = q.tcnt + 16'h0001;
					end
				end
			end
			LTS_DELAY: begin
				case (q.dunit)
					LTS_DU_STATE: dstep = tick;
					LTS_DU_WORD: dstep = occ;
					LTS_DU_TIME: dstep = 1'b1;
					default: dstep = tick;
				endcase
				if (q.dcnt == q.tdly) begin
					n.acq = LTS_IDLE;
					n.done = 1'b1;
				end else if (dstep) begin
					n.dcnt = q.dcnt + 16'h0001;
				end
			end
			default: n.acq = LTS_IDLE;
		endcase

		// Occurrence travels three sample ticks before reaching the pin
		if (tick) begin
			n.mpipe = {q.mpipe[LTS_MATCH_LAT-2:0], occ};
		end
		if (q.mpipe[LTS_MATCH_LAT-1] && !q.mout) begin
			n.mstr = LTS_MPULSE_CYC - 4'h1;
		end else if (q.mstr != '0) begin
			n.mstr = q.mstr - 4'h1;
		end
		// Level stays while the sample at the pipe end was a word, so back-to-back words hold it
		n.mout = q.men && (q.mpipe[LTS_MATCH_LAT-1] || q.mstr != '0);

		// APB: answer in the cycle after setup, with data captured at setup
		setup = apb_req.psel && !apb_req.penable;
		wr = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
		n.rdy = apb_req.psel && !(apb_req.penable && apb_rsp.pready);
		if (setup) begin
			n.prdata = rdata;
			n.pslverr = rerr;
		end
		if (wr && !rerr) begin
			if (in_words) begin
				case (wofs[LTS_WSHIFT-1:0])
					LTS_S_WVAL: n.word[widx].value = apb_req.pwdata[LTS_DW-1:0];
					LTS_S_WCARE: n.word[widx].care = apb_req.pwdata[LTS_DW-1:0];
					LTS_S_WCFG: begin
						n.word[widx].dcnt = apb_req.pwdata[LTS_CW-1:0];
						n.word[widx].inv = apb_req.pwdata[LTS_W_INV];
					end
					default: n.pslverr = 1'b1;
				endcase
			end else begin
				case (apb_req.paddr)
					LTS_A_CTRL: begin
						n.mode = lts_mode_e'(apb_req.pwdata[LTS_C_MODE+:2]);
						n.fall = apb_req.pwdata[LTS_C_FALL];
						n.gedge = apb_req.pwdata[LTS_C_GEDGE];
						n.gen = apb_req.pwdata[LTS_C_GEN];
						n.men = apb_req.pwdata[LTS_C_MEN];
						n.last = (apb_req.pwdata[LTS_C_LAST+:3] > LTS_LAST_MAX) ?
							LTS_LAST_MAX : apb_req.pwdata[LTS_C_LAST+:3];
						if (apb_req.pwdata[LTS_C_START]) begin
							n.acq = LTS_ARM;
							n.step = '0;
							n.wcnt = '0;
							n.tcnt = '0;
							n.dcnt = '0;
							n.done = 1'b0;
						end
						// Stop beats start when both are written together
						if (apb_req.pwdata[LTS_C_STOP]) begin
							n.acq = LTS_IDLE;
						end
					end
					LTS_A_TCNT: n.tpreset = apb_req.pwdata[LTS_CW-1:0];
					LTS_A_TDLY: begin
						n.tdly = apb_req.pwdata[LTS_CW-1:0];
						n.dunit = lts_dunit_e'(apb_req.pwdata[LTS_D_UNIT+:2]);
					end
					default: n.pslverr = 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			q <= '0;
		end else if (ce) begin
			q <= n;
		end
	end

	// A frozen block holds the bus off rather than drop a write
	assign apb_rsp.pready = q.rdy && ce;
	assign apb_rsp.prdata = q.prdata;
	assign apb_rsp.pslverr = q.pslverr;
	assign match_out = q.mout;
	assign acq_active = (q.acq != LTS_IDLE);
endmodule
`default_nettype wire

// file: tb/lts_target_model.sv
`timescale 1ns/10ps
`default_nettype none
module lts_target_model (
	output logic tgt_clk, // Target clock, still between frames
	output logic [lts_pkg::LTS_DW-1:0] probe_word, // Word under test
	output logic gate_in // External gate level
);
	import lts_pkg::*;
	initial begin
		tgt_clk = 1'b0;
		probe_word = '0;
		gate_in = 1'b0;
	end
	// One 80 ns frame; after hold the word turns to its inverse, never stale
	task automatic send(input logic [LTS_DW-1:0] w, input logic g);
		#3;
		probe_word = w;
		gate_in = g;
		// Clock edges land between system clock edges, never on them
		#20 tgt_clk = 1'b1;
		#40 tgt_clk = 1'b0;
		#17 probe_word = ~w;
	endtask
endmodule
`default_nettype wire

// file: tb/lts_trigger_seq_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module lts_trigger_seq_asserts (
	input wire logic clk_sys, // System clock
	input wire logic resetn, // Async reset, active low
	input wire logic ce, // Clock enable
	input wire lts_pkg::lts_apb_req_s apb_req, // APB request
	input wire lts_pkg::lts_apb_rsp_s apb_rsp, // APB response
	input wire logic match_out, // Match output
	input wire logic acq_active // Acquisition running
);
	import lts_pkg::*;
	logic rd_s, wr_ctl, men_q;
	assign rd_s = apb_req.psel && !apb_req.penable && !apb_req.pwrite && ce;
	assign wr_ctl = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite
		&& apb_req.paddr == LTS_A_CTRL;
	// Shadow of the match enable, tracked from committed writes only
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) men_q <= 1'b0;
		else if (wr_ctl) men_q <= apb_req.pwdata[LTS_C_MEN];
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	a_match_long: assert property ($rose(match_out) |-> match_out [*7])
		else $error("match pulse too short");
	a_match_off: assert property (!men_q && !match_out |=> !match_out)
		else $error("match output while disabled");
	a_acq_start: assert property (wr_ctl && apb_req.pwdata[LTS_C_START]
		&& !apb_req.pwdata[LTS_C_STOP] |=> acq_active) else $error("start not seen");
	a_acq_stop: assert property (wr_ctl && apb_req.pwdata[LTS_C_STOP]
		|=> !acq_active [*2]) else $error("stop not immediate");
	a_acq_cause: assert property ($rose(acq_active) |-> $past(wr_ctl))
		else $error("acquisition began without start");
	a_stat_act: assert property (rd_s && apb_req.paddr == LTS_A_STAT ##1 apb_rsp.pready
		|-> apb_rsp.prdata[LTS_ST_ACT] == $past(acq_active)) else $error("status active");
	a_stat_match: assert property (rd_s && apb_req.paddr == LTS_A_STAT ##1 apb_rsp.pready
		|-> apb_rsp.prdata[LTS_ST_MOUT] == $past(match_out)) else $error("status match");
	a_ctl_last: assert property (rd_s && apb_req.paddr == LTS_A_CTRL ##1 apb_rsp.pready
		|-> apb_rsp.prdata[LTS_C_LAST +: 3] <= LTS_LAST_MAX && apb_rsp.prdata[7:6] == 2'h0)
		else $error("control readback");
endmodule
bind lts_trigger_seq lts_trigger_seq_asserts u_asserts (.clk_sys(clk_sys), .resetn(resetn),
	.ce(ce), .apb_req(apb_req), .apb_rsp(apb_rsp), .match_out(match_out),
	.acq_active(acq_active));
`default_nettype wire

// file: tb/lts_trigger_seq_bench.sv
`timescale 1ns/10ps
`default_nettype none
module lts_trigger_seq_bench;
	import lts_pkg::*;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic ce = 1'b1;
	lts_apb_req_s apb_req = '0;
	lts_apb_rsp_s apb_rsp;
	wire logic tgt_clk;
	wire logic gate_in;
	wire logic [LTS_DW-1:0] probe_word;
	logic match_out, acq_active, er, inv;
	logic [31:0] rd;
	logic [15:0] v, u, w, c, p;
	int mismatches = 0;
	int check_count = 0;
	int cyc = 0;
	always #5 clk_sys = ~clk_sys;
	lts_trigger_seq dut (.clk_sys(clk_sys), .resetn(resetn), .ce(ce), .apb_req(apb_req),
		.apb_rsp(apb_rsp), .tgt_clk(tgt_clk), .probe_word(probe_word), .gate_in(gate_in),
		.match_out(match_out), .acq_active(acq_active));
	lts_target_model tgt (.tgt_clk(tgt_clk), .probe_word(probe_word), .gate_in(gate_in));
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		apb_req <= {a, 1'b1, 1'b0, wr, d};
		@(posedge clk_sys);
		apb_req.penable <= 1'b1;
		do @(posedge clk_sys); while (apb_rsp.pready !== 1'b1 && ++n < 50);
		if (n >= 50) mismatches++;
		rd = apb_rsp.prdata;
		er = apb_rsp.pslverr;
		apb_req <= '0;
	endtask
	function automatic logic fires(logic [15:0] s, logic [15:0] val, logic [15:0] m, logic i);
		return (((s ^ val) & m) == 16'h0) != i;
	endfunction
	task automatic wd(input int i, input logic [15:0] val, input logic [15:0] m, input logic x);
		apb(1'b1, 8'(LTS_A_WBASE + 16 * i), 32'(val));
		apb(1'b1, 8'(LTS_A_WBASE + 16 * i + 4), 32'(m));
		apb(1'b1, 8'(LTS_A_WBASE + 16 * i + 8), 32'(x) << LTS_W_INV);
	endtask
	// Stop first so every run begins from an idle sequence
	task automatic go(input logic [1:0] m, input logic [2:0] l, input logic [3:0] o);
		apb(1'b1, LTS_A_CTRL, 32'h80);
		apb(1'b1, LTS_A_CTRL, 32'({l, 2'b01, o, m}));
	endtask
	task automatic sa(input logic [15:0] s, input logic g, input logic e);
		tgt.send(s, g);
		// A falling-edge sample is acted on after the frame ends, so let the delay state end
		repeat (5) @(posedge clk_sys);
		chk("acq_active", 32'(e), 32'(acq_active));
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 30000) begin
			mismatches++;
			print_verdict();
		end
	end
	initial begin
		void'($urandom(32'hEF54));
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		apb(1'b0, LTS_A_STAT, 0);
		chk("status_reset", 0, rd);
		apb(1'b1, LTS_A_CTRL, 32'h700);
		apb(1'b0, LTS_A_CTRL, 0);
		chk("last_clamp", 32'(LTS_LAST_MAX) << LTS_C_LAST, rd);
		apb(1'b0, 8'h1C, 0);
		chk("unmapped_err", 1, 32'(er));
		$display("test registers done");
		repeat (8) begin
			v = 16'($urandom);
			c = 16'($urandom);
			inv = 1'($urandom);
			p = 1'($urandom) ? v : 16'($urandom);
			wd(0, v, c, inv);
			go(2'($urandom % 2), 3'h0, {3'h0, 1'($urandom)});
			sa(p, 1'b0, !fires(p, v, c, inv));
		end
		$display("test parallel done");
		v = 16'($urandom);
		u = ~v;
		w = v ^ 16'h0003;
		wd(0, v, 16'hFFFF, 1'b0);
		go(LTS_PAR, 3'h0, 4'b1000);
		// Flush occurrences left in the pipe by earlier runs
		repeat (3) tgt.send(u, 1'b0);
		tgt.send(v, 1'b0);
		tgt.send(u, 1'b0);
		chk("match_early", 0, 32'(match_out));
		tgt.send(u, 1'b0);
		chk("match_late", 1, 32'(match_out));
		$display("test match done");
		apb(1'b1, LTS_A_TCNT, 2);
		go(LTS_PAR, 3'h0, 4'b0000);
		repeat (2) sa(v, 1'b0, 1'b1);
		apb(1'b0, LTS_A_STAT, 0);
		chk("trig_count", 2, 32'(rd[31:LTS_ST_TCNT]));
		sa(v, 1'b0, 1'b0);
		apb(1'b1, LTS_A_TCNT, 0);
		$display("test preset done");
		wd(1, u, 16'hFFFF, 1'b0);
		go(LTS_SEQ, 3'h1, 4'b0000);
		sa(u, 1'b0, 1'b1);
		sa(v, 1'b0, 1'b1);
		sa(u, 1'b0, 1'b0);
		go(LTS_IMM, 3'h1, 4'b0000);
		sa(v, 1'b0, 1'b1);
		sa(w, 1'b0, 1'b1);
		sa(u, 1'b0, 1'b1);
		sa(v, 1'b0, 1'b1);
		sa(u, 1'b0, 1'b0);
		$display("test sequence done");
		wd(0, v, 16'h0, 1'b0);
		go(LTS_PAR, 3'h0, 4'b0100);
		sa(u, 1'b0, 1'b1);
		sa(u, 1'b1, 1'b0);
		wd(0, v, 16'hFFFF, 1'b0);
		go(LTS_PAR, 3'h0, 4'b0100);
		sa(v, 1'b0, 1'b1);
		sa(u, 1'b1, 1'b1);
		sa(v, 1'b1, 1'b0);
		go(LTS_PAR, 3'h0, 4'b0110);
		sa(v, 1'b1, 1'b1);
		sa(v, 1'b0, 1'b1);
		sa(v, 1'b1, 1'b0);
		$display("test gate done");
		apb(1'b1, LTS_A_TDLY, 3);
		go(LTS_PAR, 3'h0, 4'b0000);
		sa(v, 1'b0, 1'b1);
		repeat (2) sa(u, 1'b0, 1'b1);
		tgt.send(u, 1'b0);
		sa(u, 1'b0, 1'b0);
		apb(1'b1, LTS_A_TDLY, 32'h2_0028);
		go(LTS_PAR, 3'h0, 4'b0000);
		tgt.send(v, 1'b0);
		repeat (30) @(posedge clk_sys);
		chk("delay_time_mid", 1, 32'(acq_active));
		repeat (15) @(posedge clk_sys);
		chk("delay_time_end", 0, 32'(acq_active));
		apb(1'b1, LTS_A_TDLY, 0);
		$display("test delay done");
		go(LTS_PAR, 3'h0, 4'b0000);
		@(posedge clk_sys);
		chk("run_active", 1, 32'(acq_active));
		apb(1'b1, LTS_A_CTRL, 32'h80);
		@(posedge clk_sys);
		chk("manual_stop", 0, 32'(acq_active));
		$display("test stop done");
		print_verdict();
	end
endmodule
`default_nettype wire
